// ---- hdl/pbs_consts.svh ----
// Timing, offsets, field positions and reset values of the pushbutton sequencer
`ifndef PBS_CONSTS_SVH
`define PBS_CONSTS_SVH
// ====================
// Timebase
`define PBS_CLK_PERIOD_NS 100
`define PBS_TICK_PERIOD_NS 1000000
`define PBS_TICK_CYCLES (`PBS_TICK_PERIOD_NS / `PBS_CLK_PERIOD_NS)
// ====================
// Intervals in timebase ticks (1 ms each)
`define PBS_DEBOUNCE_MS 13'h0032
`define PBS_POWERUP_PRESS_MS 13'h0190
`define PBS_SHUTDOWN_MS 13'h03e8
`define PBS_KILL_PRESS_MS 13'h1388
`define PBS_STARTUP_MS 13'h1388
// ====================
// Register byte offsets
`define PBS_ADDR_CTRL 4'h0
`define PBS_ADDR_STATUS 4'h4
`define PBS_ADDR_EVENT 4'h8
// ====================
// Field positions and control reset value
`define PBS_CTRL_STAT_EN_BIT 0
`define PBS_EVENT_KILL_BIT 0
`define PBS_EVENT_POR_BIT 1
`define PBS_CTRL_RESET 1'h1
`endif

// ---- hdl/pbs_pkg.sv ----
// Types shared by the pushbutton sequencer
package pbs_pkg;
    // ====================
    // Power states
    typedef enum logic [2:0] {
        PBS_STATE_DEEP_OFF = 3'b000,
        PBS_STATE_STARTUP_FIRST = 3'b001,
        PBS_STATE_STARTUP_REPEAT = 3'b010,
        PBS_STATE_RUN = 3'b011,
        PBS_STATE_SHUTDOWN_SOFT = 3'b100,
        PBS_STATE_SHUTDOWN_HARD = 3'b101,
        PBS_STATE_OFF = 3'b110
    } pbs_state_e;

    // Pin inputs, all asynchronous to clk
    typedef struct packed {
        logic button_n;
        logic switcher_enable_in;
        logic linear_enable_in;
        logic order_select;
        logic rail_undervoltage;
        logic rail_power_on_reset;
        logic external_supply_valid;
        logic switcher_fb_good;
        logic linear_fb_good;
        logic button_status_in;
    } pbs_pins_s;

    // Avalon-MM slave request
    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } pbs_avm_req_s;

    // Whole module state
    typedef struct packed {
        pbs_pins_s sync1;
        pbs_pins_s sync2;
        logic [13:0] tick_cnt;
        logic tick;
        pbs_state_e state;
        logic [12:0] state_ms;
        logic [12:0] press_ms;
        logic armed;
        logic press_active;
        logic second_on;
        logic switcher_en;
        logic linear_en;
        logic stat_low;
        logic [12:0] stat_ms;
        logic ctrl_stat_en;
        logic ev_kill;
        logic ev_por;
        logic waitrequest;
        logic [31:0] readdata;
    } pbs_regs_s;
endpackage

// ---- hdl/pbs_sequencer.sv ----
// Pushbutton power sequencer for a two-regulator power manager
//
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
`include "pbs_consts.svh"

module pbs_sequencer
    import pbs_pkg::*;
#(
    parameter int TICK_CYCLES = `PBS_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire pbs_pins_s pins,
    input wire pbs_avm_req_s avm_req,
    output logic [31:0] avm_readdata,
    output logic avm_waitrequest,
    output logic switcher_enable_out,
    output logic linear_enable_out,
    output logic button_status_out,
    output logic button_status_oe_n
);
    localparam logic [13:0] TICK_LAST = 14'(TICK_CYCLES - 1);

    logic [1:0] rst_pipe;
    logic rst_sync_n;
    pbs_regs_s r;
    pbs_regs_s next_r;

    // ====================
    // Reset release
    // Asynchronous assert, clocked release to avoid a split first edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'h1};
        end
    end
    assign rst_sync_n = rst_pipe[1];

    // ====================
    // Next-state logic
    always_comb begin
        logic btn_low;
        logic en_any;
        logic active;
        logic kill;
        logic powerup_press;
        logic is_shut;
        logic wr;
        logic rd;
        logic [31:0] rval;
        pbs_state_e ns;
        next_r = r;
        btn_low = 1'h0;
        en_any = 1'h0;
        active = 1'h0;
        kill = 1'h0;
        powerup_press = 1'h0;
        is_shut = 1'h0;
        wr = 1'h0;
        rd = 1'h0;
        rval = 32'h0;
        ns = r.state;

        // Two-stage synchronisers on every pin
        next_r.sync1 = pins;
        next_r.sync2 = r.sync1;
        btn_low = !r.sync2.button_n;
        en_any = r.sync2.switcher_enable_in || r.sync2.linear_enable_in;

        // Millisecond timebase shared by every interval
        next_r.tick = (r.tick_cnt == TICK_LAST);
        next_r.tick_cnt = next_r.tick ? 14'h0 : r.tick_cnt + 14'h1;

        active = (r.state == PBS_STATE_RUN) || (r.state == PBS_STATE_STARTUP_FIRST)
            || (r.state == PBS_STATE_STARTUP_REPEAT);
        is_shut = (r.state == PBS_STATE_SHUTDOWN_SOFT)
            || (r.state == PBS_STATE_SHUTDOWN_HARD);

        // Press length, saturating at the kill length
        if (!btn_low) begin
            next_r.press_ms = 13'h0;
        end else if (r.tick && r.press_ms != `PBS_KILL_PRESS_MS) begin
            next_r.press_ms = r.press_ms + 13'h1;
        end

        // A press counts as a kill or status press only if it began while powered
        if (!btn_low) begin
            next_r.press_active = 1'h0;
        end else if (r.press_ms == 13'h0 && active) begin
            next_r.press_active = 1'h1;
        end
        kill = r.press_active && (r.press_ms == `PBS_KILL_PRESS_MS);

        // Power-up press needs a release first, so a held button is disarmed
        powerup_press = r.armed && (r.press_ms >= `PBS_POWERUP_PRESS_MS);
        if (!btn_low) begin
            next_r.armed = 1'h1;
        end else if (is_shut || (r.state == PBS_STATE_DEEP_OFF && !r.armed)) begin
            next_r.armed = 1'h0;
        end

        // State transitions; power-on reset and kill take precedence
        if (r.sync2.rail_power_on_reset) begin
            ns = PBS_STATE_SHUTDOWN_HARD;
        end else if (kill && r.state != PBS_STATE_SHUTDOWN_HARD
                && r.state != PBS_STATE_DEEP_OFF) begin
            ns = PBS_STATE_SHUTDOWN_HARD;
        end else begin
            case (r.state)
                PBS_STATE_DEEP_OFF, PBS_STATE_OFF: begin
                    if (en_any && !r.sync2.rail_undervoltage) begin
                        ns = PBS_STATE_RUN;
                    end else if (powerup_press || r.sync2.external_supply_valid) begin
                        ns = (r.state == PBS_STATE_OFF) ? PBS_STATE_STARTUP_REPEAT
                            : PBS_STATE_STARTUP_FIRST;
                    end
                end
                PBS_STATE_STARTUP_FIRST, PBS_STATE_STARTUP_REPEAT: begin
                    if (r.sync2.rail_undervoltage) begin
                        ns = PBS_STATE_SHUTDOWN_SOFT;
                    end else if (r.state_ms >= `PBS_STARTUP_MS) begin
                        ns = PBS_STATE_RUN;
                    end
                end
                PBS_STATE_RUN: begin
                    // Controller drops both enables to power down
                    if (!en_any || r.sync2.rail_undervoltage) begin
                        ns = PBS_STATE_SHUTDOWN_SOFT;
                    end
                end
                PBS_STATE_SHUTDOWN_SOFT: begin
                    // Only the timer is looked at here
                    if (r.state_ms >= `PBS_SHUTDOWN_MS) begin
                        ns = PBS_STATE_OFF;
                    end
                end
                PBS_STATE_SHUTDOWN_HARD: begin
                    if (r.state_ms >= `PBS_SHUTDOWN_MS) begin
                        ns = PBS_STATE_DEEP_OFF;
                    end
                end
                default: begin
                    ns = PBS_STATE_SHUTDOWN_HARD;
                end
            endcase
        end
        next_r.state = ns;

        // Dwell timer restarts on every entry, including power-on reset re-entry
        if (ns != r.state || r.sync2.rail_power_on_reset) begin
            next_r.state_ms = 13'h0;
        end else if (r.tick && r.state_ms != 13'h1fff) begin
            next_r.state_ms = r.state_ms + 13'h1;
        end

        // Regulator enables
        next_r.second_on = 1'h0;
        case (ns)
            PBS_STATE_STARTUP_FIRST, PBS_STATE_STARTUP_REPEAT: begin
                // Second regulator waits for the first to near regulation
                if (r.sync2.order_select) begin
                    next_r.second_on = r.second_on || r.sync2.linear_fb_good;
                    next_r.linear_en = 1'h1;
                    next_r.switcher_en = next_r.second_on;
                end else begin
                    next_r.second_on = r.second_on || r.sync2.switcher_fb_good;
                    next_r.switcher_en = 1'h1;
                    next_r.linear_en = next_r.second_on;
                end
            end
            PBS_STATE_RUN: begin
                next_r.switcher_en = r.sync2.switcher_enable_in;
                next_r.linear_en = r.sync2.linear_enable_in;
            end
            default: begin
                // Both regulators drop together in every other state
                next_r.switcher_en = 1'h0;
                next_r.linear_en = 1'h0;
            end
        endcase

        // Debounced status pulse with a minimum low width
        if (r.stat_low && r.tick && r.stat_ms != 13'h1fff) begin
            next_r.stat_ms = r.stat_ms + 13'h1;
        end
        if (!active || !r.ctrl_stat_en) begin
            next_r.stat_low = 1'h0;
            next_r.stat_ms = 13'h0;
        end else if (!r.stat_low) begin
            if (r.press_active && r.press_ms >= `PBS_DEBOUNCE_MS) begin
                next_r.stat_low = 1'h1;
                next_r.stat_ms = 13'h0;
            end
        end else if (!btn_low && r.stat_ms >= `PBS_DEBOUNCE_MS) begin
            next_r.stat_low = 1'h0;
        end

        // ====================
        // Avalon-MM slave: one wait cycle, then answer
        // Waitrequest drops for exactly one cycle per request
        rd = avm_req.read && r.waitrequest;
        wr = avm_req.write && r.waitrequest && !avm_req.read;
        next_r.waitrequest = !(rd || wr);
        case (avm_req.address)
            `PBS_ADDR_CTRL: rval[`PBS_CTRL_STAT_EN_BIT] = r.ctrl_stat_en;
            `PBS_ADDR_STATUS: begin
                rval[2:0] = r.state;
                rval[3] = r.switcher_en;
                rval[4] = r.linear_en;
                rval[5] = r.stat_low;
                rval[15:6] = r.sync2[9:0];
            end
            `PBS_ADDR_EVENT: begin
                rval[`PBS_EVENT_KILL_BIT] = r.ev_kill;
                rval[`PBS_EVENT_POR_BIT] = r.ev_por;
            end
            default: rval = 32'h0;
        endcase
        next_r.readdata = rd ? rval : 32'h0;
        if (wr && avm_req.address == `PBS_ADDR_CTRL) begin
            next_r.ctrl_stat_en = avm_req.writedata[`PBS_CTRL_STAT_EN_BIT];
        end
        // Sticky events, write one to clear; a new event wins over the clear
        if (wr && avm_req.address == `PBS_ADDR_EVENT) begin
            if (avm_req.writedata[`PBS_EVENT_KILL_BIT]) next_r.ev_kill = 1'h0;
            if (avm_req.writedata[`PBS_EVENT_POR_BIT]) next_r.ev_por = 1'h0;
        end
        // Only the press that forces hard shutdown marks the event, so a clear holds
        if (kill && r.state != PBS_STATE_SHUTDOWN_HARD && r.state != PBS_STATE_DEEP_OFF) begin
            next_r.ev_kill = 1'h1;
        end
        if (r.sync2.rail_power_on_reset) next_r.ev_por = 1'h1;
    end

    // ====================
    // State register; reset enters hard shutdown so the deep-off path runs
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            r <= '0;
            r.state <= PBS_STATE_SHUTDOWN_HARD;
            r.ctrl_stat_en <= `PBS_CTRL_RESET;
            r.waitrequest <= 1'h1;
            r.sync1 <= '1;
            r.sync2 <= '1;
        end else begin
            r <= next_r;
        end
    end

    // ====================
    // Outputs straight from flops, except the status drive level, which is a constant low
    assign avm_readdata = r.readdata;
    assign avm_waitrequest = r.waitrequest;
    assign switcher_enable_out = r.switcher_en;
    assign linear_enable_out = r.linear_en;
    assign button_status_out = 1'h0; // Open drain only ever pulls low
    assign button_status_oe_n = !r.stat_low;
endmodule

// ---- testbench/pbs_sequencer_assertions.sv ----
// Concurrent checks on the pushbutton sequencer ports
`timescale 1ns/1ns
module pbs_sequencer_checker
    import pbs_pkg::*;
#(
    parameter int TICK_CYCLES = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire pbs_pins_s pins,
    input wire pbs_avm_req_s avm_req,
    input wire logic [31:0] avm_readdata,
    input wire logic avm_waitrequest,
    input wire logic switcher_enable_out,
    input wire logic linear_enable_out,
    input wire logic button_status_out,
    input wire logic button_status_oe_n
);
    int btn_cnt;
    int low_cnt;
    int off_cnt;
    // ====================
    // Run lengths: button held, status pulse, both regulators off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            btn_cnt <= 0;
            low_cnt <= 0;
            off_cnt <= 0;
        end else begin
            btn_cnt <= pins.button_n ? 0 : btn_cnt + 1;
            low_cnt <= button_status_oe_n ? 0 : low_cnt + 1;
            off_cnt <= (switcher_enable_out || linear_enable_out) ? 0 : off_cnt + 1;
        end
    end
    // ====================
    // Bus handshake steps
    sequence s_req;
        (avm_req.read || avm_req.write) && avm_waitrequest;
    endsequence
    sequence s_ans;
        !avm_waitrequest ##1 avm_waitrequest;
    endsequence
    property p_bus_answer;
        @(posedge clk) disable iff (!rst_n) s_req |=> s_ans;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");
    property p_unmapped;
        @(posedge clk) disable iff (!rst_n)
        avm_req.read && avm_waitrequest && !(avm_req.address inside {4'h0, 4'h4, 4'h8})
        |=> avm_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // ====================
    // Status pulse and regulator timing; one tick of slack on the status checks, ten ticks on the minimum off time
    property p_status_debounce;
        @(posedge clk) disable iff (!rst_n)
        $fell(button_status_oe_n) |-> btn_cnt >= 49 * TICK_CYCLES;
    endproperty
    a_status_debounce: assert property (p_status_debounce) else $error("status early");
    property p_status_width;
        @(posedge clk) disable iff (!rst_n)
        $rose(button_status_oe_n) |-> low_cnt >= 49 * TICK_CYCLES;
    endproperty
    a_status_width: assert property (p_status_width) else $error("status pulse short");
    property p_min_off;
        @(posedge clk) disable iff (!rst_n)
        $rose(switcher_enable_out) || $rose(linear_enable_out)
        |-> off_cnt == 0 || off_cnt >= 990 * TICK_CYCLES;
    endproperty
    a_min_off: assert property (p_min_off) else $error("regulator back on too soon");
    property p_order_low;
        @(posedge clk) disable iff (!rst_n)
        $rose(linear_enable_out) && !pins.order_select && !pins.linear_enable_in
        |-> switcher_enable_out;
    endproperty
    a_order_low: assert property (p_order_low) else $error("linear before switcher");
    property p_order_high;
        @(posedge clk) disable iff (!rst_n)
        $rose(switcher_enable_out) && pins.order_select && !pins.switcher_enable_in
        |-> linear_enable_out;
    endproperty
    a_order_high: assert property (p_order_high) else $error("switcher before linear");
    property p_uv_off;
        @(posedge clk) disable iff (!rst_n)
        pins.rail_undervoltage [*8] |-> !switcher_enable_out && !linear_enable_out;
    endproperty
    a_uv_off: assert property (p_uv_off) else $error("regulator on in undervoltage");
    property p_por_off;
        @(posedge clk) disable iff (!rst_n)
        pins.rail_power_on_reset [*8] |-> !switcher_enable_out && !linear_enable_out;
    endproperty
    a_por_off: assert property (p_por_off) else $error("regulator on in rail reset");
endmodule

bind pbs_sequencer pbs_sequencer_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
    .clk(clk), .rst_n(rst_n), .pins(pins), .avm_req(avm_req),
    .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
    .switcher_enable_out(switcher_enable_out), .linear_enable_out(linear_enable_out),
    .button_status_out(button_status_out), .button_status_oe_n(button_status_oe_n));

// ---- testbench/pbs_ctrl_model.sv ----
// Controller model driving the two regulator enable inputs
`timescale 1ns/1ns
module pbs_ctrl_model (
    input wire logic clk,
    input wire logic sw_req,
    input wire logic lin_req,
    input wire logic obey,
    input wire logic status_n,
    output logic sw_en,
    output logic lin_en
);
    logic seen = 1'b0;
    logic down = 1'b0;
    // Software acts once the status pulse has ended, not during it
    always_ff @(posedge clk) begin
        seen <= obey && (seen || !status_n);
        down <= obey && (down || (seen && status_n));
    end
    // Power-down request drops both enables together
    assign sw_en = sw_req && !down;
    assign lin_en = lin_req && !down;
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the pushbutton sequencer
`timescale 1ns/1ns
module testbench;
    import pbs_pkg::*;
    localparam int TK = 2;
    logic clk, rst_n, wr, sw_out, lin_out, st_out, oe_n, sw_en, lin_en;
    logic btn, ord, uv, por, ext, sfb, lfb, sw_req, lin_req, obey;
    pbs_pins_s pins;
    pbs_avm_req_s req;
    logic [31:0] rdata, d;
    int errors, checked;
    // Status wire has a pull-up; only the low drive shows
    assign pins = {btn, sw_en, lin_en, ord, uv, por, ext, sfb, lfb, oe_n | st_out};
    pbs_sequencer #(.TICK_CYCLES(TK)) dut_u (
        .clk(clk), .rst_n(rst_n), .pins(pins), .avm_req(req), .avm_readdata(rdata),
        .avm_waitrequest(wr), .switcher_enable_out(sw_out), .linear_enable_out(lin_out),
        .button_status_out(st_out), .button_status_oe_n(oe_n));
    pbs_ctrl_model ctrl_u (.clk(clk), .sw_req(sw_req), .lin_req(lin_req), .obey(obey),
        .status_n(oe_n | st_out), .sw_en(sw_en), .lin_en(lin_en));
    // ====================
    // Helpers
    task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Hold the request until waitrequest is seen low, bounded
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] wd);
        int n;
        n = 0;
        req <= '{a, !w, w, wd};
        @(posedge clk);
        while (wr !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        d = rdata;
        req <= '0;
        if (n >= 50) begin
            errors++;
            $display("[ERR] %0t bus timeout", $time);
            conclude();
        end
        @(posedge clk);
    endtask
    task automatic st(input logic [2:0] s);
        bus(4'h4, 1'b0, 32'h0);
        cmp(32'(d[2:0]), 32'(s));
    endtask
    task automatic regs(input logic s, input logic l);
        cmp(32'({sw_out, lin_out}), 32'({s, l}));
    endtask
    task automatic ms(input int n);
        repeat (n * TK) @(posedge clk);
    endtask
    // ====================
    // Clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Main sequence; intervals after reset are counted in timebase ticks of TK clocks (200 ns)
    initial begin
        rst_n = 1'b0;
        req = '0;
        {btn, ord, uv, por, ext, sfb, lfb} = 7'b1000000;
        {sw_req, lin_req, obey} = 3'b000;
        errors = 0;
        checked = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        cmp(32'({wr, oe_n, sw_out, lin_out}), 32'hc);
        bus(4'h0, 1'b0, 32'h0);
        cmp(d, 32'h1);
        st(3'd5);
        bus(4'hc, 1'b0, 32'h0);
        cmp(d, 32'h0);
        ms(890);
        st(3'd5);
        ms(120);
        st(3'd0);
        btn <= 1'b0;
        ms(380);
        st(3'd0);
        ms(40);
        st(3'd1);
        regs(1'b1, 1'b0);
        sfb <= 1'b1;
        ms(3);
        regs(1'b1, 1'b1);
        {sw_req, lin_req, btn} <= 3'b111;
        ms(4900);
        st(3'd1);
        ms(150);
        st(3'd3);
        lin_req <= 1'b0;
        ms(3);
        regs(1'b1, 1'b0);
        lin_req <= 1'b1;
        ms(3);
        regs(1'b1, 1'b1);
        {obey, btn} <= 2'b10;
        ms(55);
        cmp(32'({oe_n, st_out}), 32'h0);
        btn <= 1'b1;
        ms(60);
        st(3'd4);
        regs(1'b0, 1'b0);
        btn <= 1'b0;
        ms(850);
        st(3'd4);
        ms(200);
        st(3'd6);
        ms(500);
        st(3'd6);
        {sw_req, lin_req, obey, btn, ord, sfb, lfb} <= 7'b0001100;
        ms(5);
        btn <= 1'b0;
        ms(420);
        st(3'd2);
        regs(1'b0, 1'b1);
        lfb <= 1'b1;
        ms(3);
        regs(1'b1, 1'b1);
        // Status output disabled: the long press below keeps the wire released
        bus(4'h0, 1'b1, 32'h0);
        bus(4'h0, 1'b0, 32'h0);
        cmp(d, 32'h0);
        {sw_req, lin_req, btn} <= 3'b111;
        ms(5);
        btn <= 1'b0;
        ms(4950);
        regs(1'b1, 1'b1);
        cmp(32'(oe_n), 32'h1);
        ms(100);
        st(3'd5);
        regs(1'b0, 1'b0);
        {sw_req, lin_req, btn} <= 3'b001;
        bus(4'h8, 1'b0, 32'h0);
        cmp(32'(d[0]), 32'h1);
        bus(4'h8, 1'b1, 32'h3);
        bus(4'h8, 1'b0, 32'h0);
        cmp(d, 32'h0);
        ms(980);
        st(3'd0);
        {uv, lin_req} <= 2'b11;
        ms(20);
        st(3'd0);
        uv <= 1'b0;
        ms(5);
        st(3'd3);
        regs(1'b0, 1'b1);
        uv <= 1'b1;
        ms(5);
        st(3'd4);
        regs(1'b0, 1'b0);
        {lin_req, uv, ext} <= 3'b001;
        ms(500);
        st(3'd4);
        ms(510);
        st(3'd2);
        regs(1'b1, 1'b1);
        por <= 1'b1;
        ms(5);
        st(3'd5);
        regs(1'b0, 1'b0);
        conclude();
    end
endmodule
